// ==== include/lgp_defines.svh ====
// Bit positions, sizes and timing figures of the LED PWM core
`ifndef LGP_DEFINES_SVH
`define LGP_DEFINES_SVH
`define LGP_GS_BITS 288
`define LGP_CC_BITS 216
`define LGP_PWM_W 12
`define LGP_CH 8
`define LGP_GROUPS 3
`define LGP_UD_LO 199
`define LGP_UD_HI 215
`define LGP_CC_COMMON_HI 198
`define LGP_FC_LO 192
`define LGP_FC_RANGE_LO 0
`define LGP_FC_MODE_LO 3
`define LGP_FC_REPEAT 5
`define LGP_FC_TMGRST 6
`define LGP_CNT_FULL 13'h1000
`define LGP_CNT_LAST 13'h0fff
`define LGP_CNT_8BIT 13'h0100
`define LGP_CNT_10BIT 13'h0400
`define LGP_IDLE_W 16
`define LGP_AUTO_LATCH_MS 3
`define LGP_CLK_HZ 10000000
`endif

// ==== include/lgp_pkg.sv ====
// Types and decode helpers shared by the LED PWM core modules
package lgp_pkg;
`include "lgp_defines.svh"
  typedef enum logic [1:0] {
    LGP_MODE12 = 2'b00,
    LGP_MODE10 = 2'b01,
    LGP_MODE8 = 2'b10
  } lgp_mode_type;

  typedef struct packed {
    logic [`LGP_PWM_W:0] cnt;
    logic [`LGP_CH-1:0] on;
    logic wrap;
    logic prev_clk;
  } lgp_group_type;

  typedef struct packed {
    logic [`LGP_GS_BITS-1:0] gs_latch;
    logic [`LGP_CC_BITS-1:0] cc_latch;
    logic [`LGP_CC_BITS-1:0] cc_shift;
    logic [`LGP_IDLE_W-1:0] idle;
    logic pend;
    logic prev_strb;
    logic prev_ccl;
    logic load_tgl;
    logic iblank;
    logic [`LGP_GROUPS-1:0] range;
  } lgp_core_type;

  typedef struct packed {
    logic [`LGP_GS_BITS-1:0] sr;
    logic strb_lvl;
    logic ld_seen;
  } lgp_link_type;

  // Count at which the counter mode forces every output off
  function automatic logic [`LGP_PWM_W:0] lgp_limit(input logic [1:0] m);
    case (lgp_mode_type'(m))
      LGP_MODE12: lgp_limit = `LGP_CNT_FULL;
      LGP_MODE10: lgp_limit = `LGP_CNT_10BIT;
      default: lgp_limit = `LGP_CNT_8BIT;
    endcase
  endfunction : lgp_limit
endpackage : lgp_pkg

// ==== core/lgp_sync.sv ====
// Two-flop synchroniser bank for asynchronous levels
`timescale 1ns/100ps
module lgp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lgp_sync_type;
  lgp_sync_type s_reg;
  lgp_sync_type s_next;

  if (W < 1) begin : g_bad_width
    $error("lgp_sync: W must be at least 1");
  end

  // First stage feeds only the second
  always_comb begin
    s_next = s_reg;
    s_next.s1 = d_in;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_out = s_reg.s2;
endmodule : lgp_sync

// ==== core/lgp_group.sv ====
// One colour group: PWM counter and eight channel comparators
`timescale 1ns/100ps
`include "lgp_defines.svh"
module lgp_group #(
  parameter int CH = `LGP_CH,
  parameter int W = `LGP_PWM_W
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic pwm_clk_in,
  input wire logic clear_in,
  input wire logic [1:0] mode_in,
  input wire logic [CH*W-1:0] level_in,
  output logic [CH-1:0] on_out,
  output logic wrap_out
);
  lgp_pkg::lgp_group_type s_reg;
  lgp_pkg::lgp_group_type s_next;
  logic rise;

  if (CH != `LGP_CH || W != `LGP_PWM_W) begin : g_bad_param
    $error("lgp_group: channel count and width are fixed by the state type");
  end

  assign rise = pwm_clk_in & ~s_reg.prev_clk;

  // Count edges, compare against each level; mode limit cuts short
  always_comb begin
    s_next = s_reg;
    s_next.wrap = 1'b0;
    s_next.prev_clk = pwm_clk_in;
    if (clear_in) begin
      s_next.cnt = '0;
    end else if (rise) begin
      s_next.cnt = (s_reg.cnt == `LGP_CNT_FULL) ? s_reg.cnt : s_reg.cnt + 1'b1;
      s_next.wrap = (s_reg.cnt == `LGP_CNT_LAST);
    end
    for (int i = 0; i < CH; i++) begin
      s_next.on[i] = ~clear_in && (s_next.cnt != '0) &&
                     (s_next.cnt <= {1'b0, level_in[i*W +: W]}) &&
                     (s_next.cnt < lgp_pkg::lgp_limit(mode_in));
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign on_out = s_reg.on;
  assign wrap_out = s_reg.wrap;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_start;
    clear_in ##1 (!clear_in && rise);
  endsequence

  property p_clear_zero;
    clear_in |=> (s_reg.cnt == '0) && (on_out == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");

  property p_count_step;
    (!clear_in && rise && s_reg.cnt < `LGP_CNT_FULL) |=> s_reg.cnt == $past(s_reg.cnt) + 1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter missed edge");

  property p_on_bound;
    on_out[0] |-> (s_reg.cnt != '0) && ({1'b0, $past(level_in[W-1:0])} >= s_reg.cnt);
  endproperty
  a_on_bound: assert property (p_on_bound) else $error("output on past level");

  property p_first_edge;
    s_start ##0 (level_in[W-1:0] != '0) |=> on_out[0] && (s_reg.cnt == 1);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("first edge not on");

  property p_mode_cut;
    (on_out != '0) |-> s_reg.cnt < lgp_pkg::lgp_limit($past(mode_in));
  endproperty
  a_mode_cut: assert property (p_mode_cut) else $error("output past mode limit");

  property p_wrap;
    wrap_out |-> (s_reg.cnt == `LGP_CNT_FULL) && ($past(s_reg.cnt) == `LGP_CNT_LAST);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not at 4096th edge");
endmodule : lgp_group

// ==== core/lgp_core.sv ====
// LED driver core: serial paths, data latches and three PWM groups
`timescale 1ns/100ps
`include "lgp_defines.svh"
module lgp_core #(
  parameter int AUTO_LATCH_CYCLES = `LGP_AUTO_LATCH_MS * (`LGP_CLK_HZ / 1000)
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic pixel_serial_clock_in,
  input wire logic pixel_serial_in,
  input wire logic pixel_latch_strobe_in,
  input wire logic correction_serial_clock_in,
  input wire logic correction_serial_in,
  input wire logic blank_n_in,
  input wire logic red_pwm_clock_in,
  input wire logic green_pwm_clock_in,
  input wire logic blue_pwm_clock_in,
  output logic pixel_serial_out,
  output logic correction_serial_out,
  output logic [`LGP_CH-1:0] red_channel_output_out,
  output logic [`LGP_CH-1:0] green_channel_output_out,
  output logic [`LGP_CH-1:0] blue_channel_output_out,
  output logic [`LGP_GROUPS-1:0] dot_correction_range_out
);
  localparam logic [`LGP_IDLE_W-1:0] IDLE_LAST = `LGP_IDLE_W'(AUTO_LATCH_CYCLES - 1);
  localparam int PAD = `LGP_GS_BITS - `LGP_CC_BITS;

  lgp_pkg::lgp_core_type s_reg;
  lgp_pkg::lgp_core_type s_next;
  lgp_pkg::lgp_link_type l_reg;
  lgp_pkg::lgp_link_type l_next;

  logic strb_s;
  logic blank_s;
  logic ccl_s;
  logic cd_s;
  logic edge_s;
  logic [`LGP_GROUPS-1:0] pwm_s;
  logic ld_s;
  logic strb_rise;
  logic ccl_rise;
  logic clear;
  logic ld_event;
  logic [1:0] mode;
  logic [`LGP_GROUPS-1:0] wrap;
  logic [`LGP_CH-1:0] on_w [`LGP_GROUPS];
  logic [`LGP_CH*`LGP_PWM_W-1:0] lvl [`LGP_GROUPS];

  if (AUTO_LATCH_CYCLES < 1 || AUTO_LATCH_CYCLES >= (1 << `LGP_IDLE_W)) begin : g_bad_latch
    $error("lgp_core: AUTO_LATCH_CYCLES out of range");
  end

  // Pins and the link-side strobe level enter through two flops
  lgp_sync #(
    .W(`LGP_GROUPS + 5)
  ) u_pin_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in({blue_pwm_clock_in, green_pwm_clock_in, red_pwm_clock_in, l_reg.strb_lvl,
           correction_serial_in, correction_serial_clock_in, blank_n_in,
           pixel_latch_strobe_in}),
    .q_out({pwm_s, edge_s, cd_s, ccl_s, blank_s, strb_s})
  );

  // Readout request toggle crosses into the link domain
  lgp_sync #(
    .W(1)
  ) u_load_sync (
    .clk_in(pixel_serial_clock_in),
    .resetn_in(resetn_in),
    .d_in(s_reg.load_tgl),
    .q_out(ld_s)
  );

  assign strb_rise = strb_s & ~s_reg.prev_strb;
  assign ccl_rise = ccl_s & ~s_reg.prev_ccl;
  assign mode = s_reg.cc_latch[`LGP_FC_LO + `LGP_FC_MODE_LO +: 2];
  // Internal blank behaves like the blank pin, for one cycle
  assign clear = ~blank_s | s_reg.iblank;

  // Channel i of group g sits at slot 3*i+g of the pixel latch
  for (genvar g = 0; g < `LGP_GROUPS; g++) begin : g_grp
    for (genvar i = 0; i < `LGP_CH; i++) begin : g_ch
      assign lvl[g][i*`LGP_PWM_W +: `LGP_PWM_W] =
        s_reg.gs_latch[(`LGP_GROUPS*i+g)*`LGP_PWM_W +: `LGP_PWM_W];
    end
    lgp_group u_group (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .pwm_clk_in(pwm_s[g]),
      .clear_in(clear),
      .mode_in(mode),
      .level_in(lvl[g]),
      .on_out(on_w[g]),
      .wrap_out(wrap[g])
    );
  end

  // Latch transfers and correction path; the shift words are static
  // around a strobe, so copying them across domains is safe by protocol
  always_comb begin
    s_next = s_reg;
    s_next.prev_strb = strb_s;
    s_next.prev_ccl = ccl_s;
    s_next.iblank = wrap != '0 && s_reg.cc_latch[`LGP_FC_LO + `LGP_FC_REPEAT];
    if (ccl_rise) begin
      s_next.cc_shift = {s_reg.cc_shift[`LGP_CC_BITS-2:0], cd_s};
      s_next.idle = '0;
      s_next.pend = 1'b1;
    end else if (s_reg.pend) begin
      if (s_reg.idle == IDLE_LAST) begin
        s_next.cc_latch = s_reg.cc_shift;
        s_next.pend = 1'b0;
      end else begin
        s_next.idle = s_reg.idle + 1'b1;
      end
    end
    if (strb_rise) begin
      if (!edge_s) begin
        s_next.gs_latch = l_reg.sr;
        s_next.load_tgl = ~s_reg.load_tgl;
        if (s_reg.cc_latch[`LGP_FC_LO + `LGP_FC_TMGRST]) begin
          s_next.iblank = 1'b1;
        end
      end else begin
        s_next.cc_latch[`LGP_CC_COMMON_HI:0] = l_reg.sr[`LGP_CC_COMMON_HI:0];
        s_next.cc_shift[`LGP_UD_HI:`LGP_UD_LO] = l_reg.sr[`LGP_UD_HI:`LGP_UD_LO];
      end
    end
    s_next.range = s_next.cc_latch[`LGP_FC_LO + `LGP_FC_RANGE_LO +: `LGP_GROUPS];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Link domain: shift, or reload with correction contents for readout
  assign ld_event = ld_s != l_reg.ld_seen;
  always_comb begin
    l_next = l_reg;
    l_next.strb_lvl = pixel_latch_strobe_in; // strobe level at this edge
    if (ld_event) begin
      l_next.ld_seen = ld_s;
      l_next.sr = {{PAD{1'b0}}, s_reg.cc_latch};
    end else begin
      l_next.sr = {l_reg.sr[`LGP_GS_BITS-2:0], pixel_serial_in};
    end
  end

  always_ff @(posedge pixel_serial_clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // Outputs straight from flops
  assign pixel_serial_out = l_reg.sr[`LGP_GS_BITS-1];
  assign correction_serial_out = s_reg.cc_shift[`LGP_CC_BITS-1];
  assign red_channel_output_out = on_w[0];
  assign green_channel_output_out = on_w[1];
  assign blue_channel_output_out = on_w[2];
  assign dot_correction_range_out = s_reg.range;

  property p_shift;
    @(posedge pixel_serial_clock_in) disable iff (!resetn_in)
    !ld_event |=> (l_reg.sr[0] == $past(pixel_serial_in)) &&
      (l_reg.sr[`LGP_GS_BITS-1:1] == $past(l_reg.sr[`LGP_GS_BITS-2:0]));
  endproperty
  a_shift: assert property (p_shift) else $error("common shift wrong");

  property p_gs_load;
    @(posedge clk_in) disable iff (!resetn_in)
    strb_rise && !edge_s |=> s_reg.gs_latch == $past(l_reg.sr);
  endproperty
  a_gs_load: assert property (p_gs_load) else $error("pixel latch not loaded");

  property p_cc_load;
    @(posedge clk_in) disable iff (!resetn_in)
    strb_rise && edge_s |=> (s_reg.cc_latch[`LGP_CC_COMMON_HI:0] ==
      $past(l_reg.sr[`LGP_CC_COMMON_HI:0])) && (s_reg.cc_shift[`LGP_UD_HI:`LGP_UD_LO] ==
      $past(l_reg.sr[`LGP_UD_HI:`LGP_UD_LO]));
  endproperty
  a_cc_load: assert property (p_cc_load) else $error("correction copy wrong");

  property p_auto_latch;
    @(posedge clk_in) disable iff (!resetn_in)
    s_reg.pend && s_reg.idle == IDLE_LAST && !ccl_rise && !strb_rise |=>
      !s_reg.pend && s_reg.cc_latch == $past(s_reg.cc_shift);
  endproperty
  a_auto_latch: assert property (p_auto_latch) else $error("auto latch missed");

  property p_cc_shift;
    @(posedge clk_in) disable iff (!resetn_in)
    ccl_rise && !strb_rise |=> s_reg.cc_shift[0] == $past(cd_s) && s_reg.pend;
  endproperty
  a_cc_shift: assert property (p_cc_shift) else $error("correction shift wrong");

  property p_iblank;
    @(posedge clk_in) disable iff (!resetn_in)
    strb_rise && !edge_s && s_reg.cc_latch[`LGP_FC_LO + `LGP_FC_TMGRST] |=>
      s_reg.iblank ##1 (red_channel_output_out == '0);
  endproperty
  a_iblank: assert property (p_iblank) else $error("internal blank missing");

  property p_blank_off;
    @(posedge clk_in) disable iff (!resetn_in)
    !blank_s |=> (red_channel_output_out | green_channel_output_out |
      blue_channel_output_out) == '0;
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("output on during blank");
endmodule : lgp_core

// ==== test/lgp_ctrl_model.sv ====
// Display controller model: drives serial ports, blank and PWM clocks
`timescale 1ns/100ps
module lgp_ctrl_model (
  input wire logic clk_in,
  input wire logic pixel_serial_out_in,
  output logic pixel_serial_clock_out,
  output logic pixel_serial_data_out,
  output logic pixel_latch_strobe_out,
  output logic correction_serial_clock_out,
  output logic correction_serial_data_out,
  output logic blank_n_out,
  output logic [2:0] pwm_clock_out
);
  // Blank held low from power-up until levels are loaded
  initial begin
    pixel_serial_clock_out = 1'b0;
    pixel_serial_data_out = 1'b0;
    pixel_latch_strobe_out = 1'b0;
    correction_serial_clock_out = 1'b0;
    correction_serial_data_out = 1'b0;
    blank_n_out = 1'b0;
    pwm_clock_out = 3'b000;
  end

  // Link clock runs only inside a frame; strobe level set before the last edge
  task automatic shift_pixel(input logic [287:0] d, input logic lvl, output logic [287:0] q);
    q = '0;
    for (int i = 287; i >= 0; i--) begin
      pixel_serial_data_out = d[i];
      pixel_latch_strobe_out = (i == 0) ? lvl : 1'b0;
      #3 pixel_serial_clock_out = ~pixel_serial_clock_out;
      #3 pixel_serial_clock_out = ~pixel_serial_clock_out;
      q = {q[286:0], pixel_serial_out_in};
    end
    // Strobe drops again so the latching rise comes from strobe() alone
    pixel_latch_strobe_out = 1'b0;
    // Released line shows the inverse so stale data cannot pass
    pixel_serial_data_out = ~pixel_serial_data_out;
  endtask : shift_pixel

  // No serial clock runs while the strobe is being taken
  task automatic strobe();
    @(posedge clk_in) #1 pixel_latch_strobe_out = 1'b1;
    repeat (8) @(posedge clk_in);
    #1 pixel_latch_strobe_out = 1'b0;
    repeat (8) @(posedge clk_in);
    #50;
  endtask : strobe

  // Correction clock kept slow since the core samples it
  task automatic shift_corr(input logic [215:0] d);
    for (int i = 215; i >= 0; i--) begin
      @(posedge clk_in) #1 correction_serial_data_out = d[i];
      repeat (3) @(posedge clk_in);
      #1 correction_serial_clock_out = ~correction_serial_clock_out;
      repeat (4) @(posedge clk_in);
      #1 correction_serial_clock_out = ~correction_serial_clock_out;
    end
    correction_serial_data_out = ~correction_serial_data_out;
  endtask : shift_corr

  // PWM clock pulses on the selected groups, ends mid-cycle
  task automatic pwm_pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_in) #1 pwm_clock_out = m;
      repeat (3) @(posedge clk_in);
      #1 pwm_clock_out = 3'b000;
      repeat (5) @(posedge clk_in);
      #50;
    end
  endtask : pwm_pulse

  // Fastest PWM clock the core can count: one cycle high, one low
  task automatic pwm_fast(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_in) #1 pwm_clock_out = m;
      @(posedge clk_in) #1 pwm_clock_out = 3'b000;
    end
    repeat (5) @(posedge clk_in);
    #50;
  endtask : pwm_fast

  task automatic set_blank(input logic v);
    @(posedge clk_in) #1 blank_n_out = v;
    repeat (5) @(posedge clk_in);
    #50;
  endtask : set_blank
endmodule : lgp_ctrl_model

// ==== test/lgp_core_tb.sv ====
// Self-checking bench for the LED PWM core with a controller model
`timescale 1ns/100ps
module lgp_core_tb;
  localparam int AUTO_CYC = 20;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sck, sdi, stb, cck, cdi, blank_n;
  logic [2:0] pclk;
  logic pso, cso;
  logic [7:0] red, green, blue;
  logic [2:0] range;
  logic [287:0] gs, rb, cmn;
  logic [215:0] cc;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 clk_in = ~clk_in;

  lgp_ctrl_model i_lgp_ctrl_model (.clk_in(clk_in), .pixel_serial_out_in(pso),
    .pixel_serial_clock_out(sck), .pixel_serial_data_out(sdi),
    .pixel_latch_strobe_out(stb), .correction_serial_clock_out(cck),
    .correction_serial_data_out(cdi), .blank_n_out(blank_n), .pwm_clock_out(pclk));

  lgp_core #(.AUTO_LATCH_CYCLES(AUTO_CYC)) i_lgp_core (.clk_in(clk_in),
    .resetn_in(resetn_in), .pixel_serial_clock_in(sck), .pixel_serial_in(sdi),
    .pixel_latch_strobe_in(stb), .correction_serial_clock_in(cck),
    .correction_serial_in(cdi), .blank_n_in(blank_n), .red_pwm_clock_in(pclk[0]),
    .green_pwm_clock_in(pclk[1]), .blue_pwm_clock_in(pclk[2]),
    .pixel_serial_out(pso), .correction_serial_out(cso),
    .red_channel_output_out(red), .green_channel_output_out(green),
    .blue_channel_output_out(blue), .dot_correction_range_out(range));

  task automatic check(input string what, input logic [287:0] seen, input logic [287:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    // Green0 left at zero as for an unconnected channel
    gs = '0;
    gs[11:0] = 12'h003;
    gs[35:24] = 12'hfff;
    gs[47:36] = 12'h001;
    gs[59:48] = 12'h002; // Green1 lit so the green path is seen
    // User bits, function 8-bit mode with range 101, brightness, dot correction
    cc = {17'h1_5a5a, 7'h15, 24'h30_2010, {21{8'ha8}}};
    repeat (10) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    i_lgp_ctrl_model.pwm_pulse(3'b111, 2);
    check("outputs in blank", 288'({red, green, blue}), 288'h0);
    $display("test blank done");

    // Pixel load, then red count walks across the levels
    i_lgp_ctrl_model.shift_pixel(gs, 1'b0, rb);
    i_lgp_ctrl_model.strobe();
    i_lgp_ctrl_model.set_blank(1'b1);
    for (int n = 1; n <= 5; n++) begin
      i_lgp_ctrl_model.pwm_pulse(3'b001, 1);
      check("red", 288'(red), 288'({(n == 1), (n <= 3)}));
      check("green", 288'(green), 288'h0);
      check("blue", 288'(blue), 288'h0);
    end
    i_lgp_ctrl_model.pwm_pulse(3'b100, 1);
    check("blue", 288'(blue), 288'h1);
    i_lgp_ctrl_model.set_blank(1'b0);
    check("outputs off", 288'({red, green, blue}), 288'h0);
    i_lgp_ctrl_model.set_blank(1'b1);
    i_lgp_ctrl_model.pwm_pulse(3'b001, 1);
    check("red restart", 288'(red), 288'h3);
    $display("test pwm done");

    // Correction port write and self-timed latch
    i_lgp_ctrl_model.set_blank(1'b0);
    i_lgp_ctrl_model.shift_corr(cc);
    repeat (5) @(posedge clk_in);
    #50;
    check("corr out", 288'(cso), 288'(cc[215]));
    check("range early", 288'(range), 288'h0);
    repeat (AUTO_CYC + 10) @(posedge clk_in);
    check("range", 288'(range), 288'h5);
    $display("test correction done");

    // Pixel load then read the correction latch back
    i_lgp_ctrl_model.shift_pixel(gs, 1'b0, rb);
    i_lgp_ctrl_model.strobe();
    i_lgp_ctrl_model.shift_pixel(gs, 1'b0, rb);
    check("readback", rb, {2'b00, 72'h0, cc[215:2]});
    $display("test readback done");

    // 8-bit mode cuts the full-scale blue0 at 256
    i_lgp_ctrl_model.set_blank(1'b1);
    i_lgp_ctrl_model.pwm_pulse(3'b100, 255);
    check("blue 255", 288'(blue), 288'h1);
    i_lgp_ctrl_model.pwm_pulse(3'b100, 1);
    check("blue 256", 288'(blue), 288'h0);
    $display("test mode done");

    // Correction write over the pixel port, long after the last correction clock
    i_lgp_ctrl_model.set_blank(1'b0);
    cmn = '0;
    // Range 010, 12-bit mode, auto repeat and timing reset on
    cmn[198:192] = 7'h62;
    i_lgp_ctrl_model.shift_pixel(cmn, 1'b1, rb);
    i_lgp_ctrl_model.strobe();
    check("range common", 288'(range), 288'h2);
    check("user bit", 288'(cso), 288'h0);
    $display("test common path done");

    // Timing reset on a strobe and auto repeat at 4096 raise the internal blank
    i_lgp_ctrl_model.shift_pixel(gs, 1'b0, rb);
    i_lgp_ctrl_model.strobe();
    i_lgp_ctrl_model.set_blank(1'b1);
    i_lgp_ctrl_model.pwm_pulse(3'b111, 1);
    check("green", 288'(green), 288'h2);
    i_lgp_ctrl_model.strobe();
    check("strobe blank", 288'({red, green, blue}), 288'h0);
    i_lgp_ctrl_model.pwm_pulse(3'b001, 1);
    check("red after strobe", 288'(red), 288'h3);
    i_lgp_ctrl_model.pwm_fast(3'b100, 4095);
    check("blue 4095", 288'(blue), 288'h1);
    i_lgp_ctrl_model.pwm_fast(3'b100, 1);
    check("red after repeat", 288'(red), 288'h0);
    $display("test internal blank done");
    wrap_up();
  end
endmodule : lgp_core_tb
